/* lgc_consts.vh */
// constants for the line interface global control register bank
// assumes byte-wide registers, each in one aligned axi4-lite word
`ifndef LGC_CONSTS_VH
`define LGC_CONSTS_VH
// printed offsets are register indexes; byte address = index * 4
`define LGC_IDX_TX_LO 8'h00
`define LGC_IDX_RX_LO 8'h08
`define LGC_IDX_IRQEN_LO 8'h60
`define LGC_IDX_IRQST_LO 8'h61
`define LGC_IDX_PART 8'h6E
`define LGC_IDX_REV 8'h6F
`define LGC_IDX_TX_HI 8'h80
`define LGC_IDX_RX_HI 8'h88
`define LGC_IDX_CH11_CTRL 8'hD6
`define LGC_IDX_CH11_JIT 8'hD7
`define LGC_IDX_CH11_ERR_HI 8'hDA
`define LGC_IDX_CH11_ERR_LO 8'hDB
`define LGC_IDX_CH11_ERR_HOLD 8'hDC
`define LGC_IDX_IRQEN_HI 8'hE0
`define LGC_IDX_IRQST_HI 8'hE1
// own registers for source flags, sticky irq status and mask
`define LGC_IDX_SRC_LO 8'hF0
`define LGC_IDX_SRC_HI 8'hF1
`define LGC_IDX_STICKY 8'hF2
`define LGC_IDX_MASK 8'hF3
`define LGC_NCH_HALF 6
// word index bits of the byte address, and the bits that must be zero
`define LGC_IDX_LSB 2
`define LGC_IDX_MSB 9
`define LGC_MAP_LSB 10
`define LGC_MAP_TOP 22'h000000
`define LGC_RESET_BYTE 8'h00
`define LGC_RESP_OKAY 2'b00
`endif

/* lgc_regs.v */
// global control register bank of a twelve-channel line interface unit
// assumes an axi4-lite master on clk; per-channel source flags arrive from channel logic
`timescale 1ns/10ps
`default_nettype none
`include "lgc_consts.vh"

// Contract
// - transmit enable for channels 0..5 at 0x00, bits 7:6 reserved
// - transmit enable for channels 6..11 at 0x80, same bit order
// - receive enable for channels 0..5 at 0x08, bits 7:6 reserved
// - receive enable for channels 6..11 at 0x88, same bit order
// - transmit bit zero turns driver off and tristates both line outputs
// - transmit bit one turns that channel's driver on
// - driver on only while master enable pin is high, ANDed per channel
// - receive bit zero turns receiver off, inputs high impedance
// - receive bit one turns that channel's receiver on
// - interrupt enable 0x60 and read-only status 0x61 for channels 0..5
// - interrupt enable 0xE0 and read-only status 0xE1 for channels 6..11
// - fixed part number at 0x6E and revision at 0x6F, writes ignored
// - channel 11 control at 0xD6 and jitter control at 0xD7, read/write
// - channel 11 error counter high 0xDA, low 0xDB, hold 0xDC, read/write
// - source interrupt status clears its pending flags when read; here only reads of 0xF0/0xF1 clear them, reads of 0x61/0xE1 do not
module lgc_regs #(
  parameter [7:0] PART_ID = 8'h5A, // arbitrary value
  parameter [7:0] REV_ID = 8'h01, // arbitrary value
  parameter NCH = 12
) (
  input wire clk,
  input wire arst_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire master_tx_enable,
  input wire [11:0] source_irq_event,
  output reg [11:0] line_driver_on,
  output reg [11:0] line_out_oe,
  output reg [11:0] line_receiver_on,
  output reg [11:0] line_in_enable,
  output reg chan_irq,
  output reg irq
);
  localparam H = `LGC_NCH_HALF;

  // transmit and receive enables, one bit per channel
  reg [H-1:0] tx_lo_q;
  reg [H-1:0] tx_hi_q;
  reg [H-1:0] rx_lo_q;
  reg [H-1:0] rx_hi_q;

  // channel irq enables
  reg [H-1:0] irq_en_lo_q;
  reg [H-1:0] irq_en_hi_q;

  // last channel bytes, plain storage: the counters live in the channel logic
  reg [7:0] ch11_ctrl_q;
  reg [7:0] ch11_jit_q;
  reg [7:0] ch11_err_hi_q;
  reg [7:0] ch11_err_lo_q;
  reg [7:0] ch11_err_hold_q;

  // pending source flags, sticky status and its mask
  reg [11:0] src_q;
  reg [11:0] src_d;
  reg [H-1:0] sticky_q;
  reg [H-1:0] sticky_d;
  reg [H-1:0] mask_q;

  // master pin synchroniser
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;
  reg pin_q;

  // write address and data held until both are in
  reg [31:0] aw_q;
  reg [7:0] wd_q;
  reg [3:0] ws_q;
  reg aw_have_q;
  reg w_have_q;

  // read mux
  reg [7:0] rdat_d;

  wire [11:0] chan_pend;
  wire [11:0] irq_en_all;
  wire [7:0] widx;
  wire [7:0] ridx;
  wire w_in_map;
  wire r_in_map;
  wire wr_go;
  wire wr_en;
  wire rd_go;
  wire wlane;
  wire [H-1:0] sticky_clr;
  wire [H-1:0] sticky_set;

  assign chan_pend = src_q;
  assign irq_en_all = {irq_en_hi_q, irq_en_lo_q};
  assign widx = aw_q[`LGC_IDX_MSB:`LGC_IDX_LSB];
  assign ridx = s_axi_araddr[`LGC_IDX_MSB:`LGC_IDX_LSB];
  // anything above the 256-word window is a hole
  assign w_in_map = (aw_q[31:`LGC_MAP_LSB] == `LGC_MAP_TOP);
  assign r_in_map = (s_axi_araddr[31:`LGC_MAP_LSB] == `LGC_MAP_TOP);
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_en = wr_go && w_in_map;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  // registers are one byte wide, so only lane 0 can write
  assign wlane = wr_en && ws_q[0];
  assign sticky_clr = (wlane && widx == `LGC_IDX_STICKY) ? wd_q[H-1:0] : {H{1'b0}};
  assign sticky_set = chan_pend[H-1:0];

  // master pin: three flops, a change is taken once second and third agree
  // the filter costs about five cycles before the drivers follow
  // reset low keeps every driver off until the pin has settled
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      pin_s1_q <= master_tx_enable;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
    end
  end

  // read mux; reserved bits and holes read as zero
  // flag, sticky and mask registers sit in the unused top of the map
  always @* begin
    rdat_d = `LGC_RESET_BYTE;
    case (ridx)
      `LGC_IDX_TX_LO: rdat_d = {2'h0, tx_lo_q};
      `LGC_IDX_TX_HI: rdat_d = {2'h0, tx_hi_q};
      `LGC_IDX_RX_LO: rdat_d = {2'h0, rx_lo_q};
      `LGC_IDX_RX_HI: rdat_d = {2'h0, rx_hi_q};
      `LGC_IDX_IRQEN_LO: rdat_d = {2'h0, irq_en_lo_q};
      `LGC_IDX_IRQST_LO: rdat_d = {2'h0, chan_pend[H-1:0]};
      `LGC_IDX_IRQEN_HI: rdat_d = {2'h0, irq_en_hi_q};
      `LGC_IDX_IRQST_HI: rdat_d = {2'h0, chan_pend[11:H]};
      `LGC_IDX_PART: rdat_d = PART_ID;
      `LGC_IDX_REV: rdat_d = REV_ID;
      `LGC_IDX_CH11_CTRL: rdat_d = ch11_ctrl_q;
      `LGC_IDX_CH11_JIT: rdat_d = ch11_jit_q;
      `LGC_IDX_CH11_ERR_HI: rdat_d = ch11_err_hi_q;
      `LGC_IDX_CH11_ERR_LO: rdat_d = ch11_err_lo_q;
      `LGC_IDX_CH11_ERR_HOLD: rdat_d = ch11_err_hold_q;
      `LGC_IDX_SRC_LO: rdat_d = {2'h0, src_q[H-1:0]};
      `LGC_IDX_SRC_HI: rdat_d = {2'h0, src_q[11:H]};
      `LGC_IDX_STICKY: rdat_d = {2'h0, sticky_q};
      `LGC_IDX_MASK: rdat_d = {2'h0, mask_q};
      default: rdat_d = `LGC_RESET_BYTE;
    endcase
    if (!r_in_map) begin
      rdat_d = `LGC_RESET_BYTE;
    end
  end

  // pending source flags; a new event wins over the clear-on-read
  // an event held high by the channel logic keeps its flag set
  always @* begin
    src_d = src_q;
    if (rd_go && r_in_map && ridx == `LGC_IDX_SRC_LO) begin
      src_d[H-1:0] = {H{1'b0}};
    end
    if (rd_go && r_in_map && ridx == `LGC_IDX_SRC_HI) begin
      src_d[11:H] = {H{1'b0}};
    end
    src_d = src_d | source_irq_event;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_q <= 12'h000;
    end else begin
      src_q <= src_d;
    end
  end

  // sticky status: set wins over write-one-to-clear in the same cycle
  always @* begin
    sticky_d = sticky_q & ~sticky_clr;
    sticky_d = sticky_d | sticky_set;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sticky_q <= {H{1'b0}};
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // write address channel; readies stay low until the response is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      aw_have_q <= 1'b0;
      aw_q <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // write data channel; only the low byte and the strobes are kept
  // a write without lane 0 completes with okay but changes nothing
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      w_have_q <= 1'b0;
      wd_q <= `LGC_RESET_BYTE;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata[7:0];
        ws_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response, one cycle after address and data are both held
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LGC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_bresp <= `LGC_RESP_OKAY;
    end
  end

  // enables for the line drivers and receivers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_lo_q <= {H{1'b0}};
      tx_hi_q <= {H{1'b0}};
      rx_lo_q <= {H{1'b0}};
      rx_hi_q <= {H{1'b0}};
    end else if (wlane) begin
      case (widx)
        `LGC_IDX_TX_LO: tx_lo_q <= wd_q[H-1:0];
        `LGC_IDX_TX_HI: tx_hi_q <= wd_q[H-1:0];
        `LGC_IDX_RX_LO: rx_lo_q <= wd_q[H-1:0];
        `LGC_IDX_RX_HI: rx_hi_q <= wd_q[H-1:0];
        default: begin
        end
      endcase
    end
  end

  // channel irq enables; status halves are read-only and ignore writes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_lo_q <= {H{1'b0}};
      irq_en_hi_q <= {H{1'b0}};
      mask_q <= {H{1'b0}};
    end else if (wlane) begin
      case (widx)
        `LGC_IDX_IRQEN_LO: irq_en_lo_q <= wd_q[H-1:0];
        `LGC_IDX_IRQEN_HI: irq_en_hi_q <= wd_q[H-1:0];
        `LGC_IDX_MASK: mask_q <= wd_q[H-1:0];
        default: begin
        end
      endcase
    end
  end

  // last channel bytes; part and revision have no storage, so writes vanish
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch11_ctrl_q <= `LGC_RESET_BYTE;
      ch11_jit_q <= `LGC_RESET_BYTE;
      ch11_err_hi_q <= `LGC_RESET_BYTE;
      ch11_err_lo_q <= `LGC_RESET_BYTE;
      ch11_err_hold_q <= `LGC_RESET_BYTE;
    end else if (wlane) begin
      case (widx)
        `LGC_IDX_CH11_CTRL: ch11_ctrl_q <= wd_q;
        `LGC_IDX_CH11_JIT: ch11_jit_q <= wd_q;
        `LGC_IDX_CH11_ERR_HI: ch11_err_hi_q <= wd_q;
        `LGC_IDX_CH11_ERR_LO: ch11_err_lo_q <= wd_q;
        `LGC_IDX_CH11_ERR_HOLD: ch11_err_hold_q <= wd_q;
        default: begin
        end
      endcase
    end
  end

  // read channel, data one cycle after the address is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LGC_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_rdata <= {24'h000000, rdat_d};
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      s_axi_rresp <= `LGC_RESP_OKAY;
    end
  end

  // line controls registered so every output comes from a flop
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_driver_on <= 12'h000;
      line_out_oe <= 12'h000;
      line_receiver_on <= 12'h000;
      line_in_enable <= 12'h000;
    end else begin
      line_driver_on <= {tx_hi_q, tx_lo_q} & {NCH{pin_q}};
      line_out_oe <= {tx_hi_q, tx_lo_q} & {NCH{pin_q}};
      line_receiver_on <= {rx_hi_q, rx_lo_q};
      line_in_enable <= {rx_hi_q, rx_lo_q};
    end
  end

  // interrupt outputs
  // irq is a level, high while an unmasked sticky bit stays set
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      chan_irq <= |(chan_pend & irq_en_all);
      irq <= |(sticky_q & mask_q);
    end
  end
endmodule
`default_nettype wire

/* lgc_regs_monitor.sv */
// checker bound to the global control register bank
// assumes one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module lgc_regs_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic master_tx_enable,
  input wire logic irq,
  input wire logic [11:0] line_driver_on,
  input wire logic [11:0] line_out_oe,
  input wire logic [11:0] line_receiver_on,
  input wire logic [11:0] line_in_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_oe_drv: assert property (line_out_oe == line_driver_on) else $error("bad oe");
  // pin passes three sync flops, so six low cycles must clear every driver
  a_pin_drv: assert property (!master_tx_enable [*6] |-> !line_driver_on) else $error("driver on");
  a_in_rx: assert property (line_in_enable == line_receiver_on) else $error("bad in");
  // receivers follow a register write, which raises bvalid one edge earlier
  a_rx_wr: assert property (!$stable(line_receiver_on) |-> $past(s_axi_bvalid)) else $error("rx moved");
  a_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00) else $error("bad bresp");
  a_r_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00) else $error("bad rresp");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
  a_r_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  c_irq: cover property (irq);
  c_drv: cover property (|line_driver_on);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind lgc_regs lgc_regs_monitor u_mon (.*);
`default_nettype wire

/* lgc_host.sv */
// host model: axi4-lite master for the register bank
// assumes the bench calls wr and rd one at a time
`timescale 1ns/10ps
`default_nettype none
module lgc_host (
  input wire clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  output logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
  initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid,
    s_axi_bready, s_axi_arvalid, s_axi_rready} = {96'h0, 4'hF, 5'h0};
  // byte address is four times the register index
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic a = 0;
    logic w = 0;
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(a && w)) begin
      @(posedge clk);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !a;
      s_axi_wvalid <= !w;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d);
    s_axi_araddr <= {22'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// bench: host model, byte model of the map, pin and irq checks
// assumes lgc_host as the only bus master
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, arst_n = 0, master_tx_enable = 0, chan_irq, irq;
  logic [11:0] source_irq_event = '0, line_driver_on, line_out_oe, line_receiver_on, line_in_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] m [256];
  logic [7:0] aq [$] = '{8'h00, 8'h08, 8'h80, 8'h88, 8'h60, 8'hE0, 8'h61, 8'hE1, 8'h6E, 8'h6F,
    8'hD6, 8'hD7, 8'hDA, 8'hDB, 8'hDC, 8'h10};
  int n_fail = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  // part and revision values are arbitrary
  lgc_regs #(.PART_ID(8'hC3), .REV_ID(8'h07)) u_lgc_regs (.*, .s_axi_bresp(), .s_axi_rresp());
  lgc_host u_host (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] wm(input logic [7:0] i);
    case (i)
      8'h00, 8'h08, 8'h80, 8'h88, 8'h60, 8'hE0: wm = 8'h3F;
      8'hD6, 8'hD7, 8'hDA, 8'hDB, 8'hDC: wm = 8'hFF;
      default: wm = 8'h00;
    endcase
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    m[8'h6E] = 8'hC3;
    m[8'h6F] = 8'h07;
    got = $urandom(32'h411cf604);
    repeat (10) @(posedge clk);
    arst_n <= 1;
    for (int r = 0; r < 5; r++) begin
      foreach (aq[k]) begin
        u_host.rd(aq[k], got);
        chk(got, {24'h0, m[aq[k]]});
      end
      master_tx_enable <= r[0];
      foreach (aq[k]) begin
        got = $urandom;
        u_host.wr(aq[k], got[7:0]);
        m[aq[k]] = m[aq[k]] & ~wm(aq[k]) | got[7:0] & wm(aq[k]);
      end
      repeat (6) @(posedge clk);
      chk(line_driver_on, {m[8'h80][5:0], m[8'h00][5:0]} & {12{r[0]}});
      chk(line_receiver_on, {m[8'h88][5:0], m[8'h08][5:0]});
      chk(line_out_oe, {m[8'h80][5:0], m[8'h00][5:0]} & {12{r[0]}});
      chk(line_in_enable, {m[8'h88][5:0], m[8'h08][5:0]});
    end
    u_host.wr(8'h60, 8'h04);
    source_irq_event <= 12'h004;
    @(posedge clk);
    source_irq_event <= 12'h000;
    repeat (3) @(posedge clk);
    chk(chan_irq, 1);
    chk(irq, 0);
    u_host.wr(8'hF3, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    u_host.rd(8'h61, got);
    chk(got, 32'h4);
    u_host.rd(8'hF0, got);
    chk(got, 32'h4);
    u_host.rd(8'hF0, got);
    chk(got, 32'h0);
    chk(chan_irq, 0);
    u_host.wr(8'hF2, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    final_report();
  end
endmodule
`default_nettype wire
